// ==== src/lsc_readback.sv ====
/*
  LIN slave readback of short status and calibrated modulation values.
  Takes header identifiers and frame bytes from a LIN frame engine on aclk,
  returns response bytes to it, and exposes control over AXI4-Lite.
*/
// Decided for this implementation: the AXI4-Lite register port and the placing of the registers.
// Function
// - short status read never clears latched flags
// - status byte: shutdown, warning, UV, retry, LEDs, LIN
// - LIN error is OR of all errors
// - LED error set when code nonzero
// - retry bit while recovering from errors
// - undervoltage sticky, cleared only by full status
// - readback returns calibrated modulation register contents
// - same request; eight data byte answer
// - overflow at bit 3; upper ones for 1,2
// - channel 3 upper byte holds intensity
// - classic checksum over data, checked and sent
`timescale 1ns/1ps
`include "lsc_consts.svh"
module lsc_readback #(
  parameter int LIN_ERR_W = 4
) (
  // clock and reset
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // axi4-lite slave
  input  wire logic [3:0]           awaddr,
  input  wire logic                 awvalid,
  output logic                      awready,
  input  wire logic [31:0]          wdata,
  input  wire logic [3:0]           wstrb,
  input  wire logic                 wvalid,
  output logic                      wready,
  output logic      [1:0]           bresp,
  output logic                      bvalid,
  input  wire logic                 bready,
  input  wire logic [3:0]           araddr,
  input  wire logic                 arvalid,
  output logic                      arready,
  output logic      [31:0]          rdata,
  output logic      [1:0]           rresp,
  output logic                      rvalid,
  input  wire logic                 rready,
  // lin frame engine
  input  wire logic                 hdr_valid,
  input  wire logic [7:0]           hdr_id,
  input  wire logic                 rx_valid,
  input  wire logic [7:0]           rx_byte,
  output logic                      tx_valid,
  input  wire logic                 tx_ready,
  output logic      [7:0]           tx_byte,
  output logic                      tx_last,
  // device state
  input  wire lsc_pkg::lsc_diag_t   diag,
  input  wire logic [LIN_ERR_W-1:0] lin_err_vec,
  input  wire logic                 vbb_uv_event,
  input  wire logic                 full_status_clear,
  input  wire lsc_pkg::lsc_color_t  color,
  // interrupt
  output logic                      irq
);
  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  lsc_pkg::lsc_state_t state_ff, nxt_state;
  logic [3:0]          idx_ff, nxt_idx;
  logic [5:0]          req_addr_ff;
  logic                req_pfx_ok_ff;
  logic                req_fill_ok_ff;
  logic                uv_ff;
  logic                cks_err_ff;
  logic [7:0]          sts_snap_ff;
  lsc_pkg::lsc_color_t col_snap_ff;
  logic                is_col_ff;
  logic                tx_last_ff;
  logic [5:0]          node_addr_ff;
  logic                resp_en_ff;
  logic [3:0]          evt_ff;
  logic [3:0]          mask_ff;
  logic                irq_ff;
  logic                bvalid_ff;
  logic [1:0]          bresp_ff;
  logic                rvalid_ff;
  logic [1:0]          rresp_ff;
  logic [31:0]         rdata_ff;

  // --------------------------------------------------------------------------
  // decode
  // --------------------------------------------------------------------------
  logic       hdr_go, hdr_req, hdr_sts, hdr_col, rsp_go;
  logic       rx_take, rx_end, rx_ok, req_match;
  logic       load_last, tx_take, tx_done;
  logic [7:0] rx_chk, tx_chk, addr_byte, data_byte, wr_byte, status_byte;
  logic [3:0] last_idx;
  logic [2:0] led_err;
  logic       lin_error;
  logic [7:0] col_pay [8];

  // a header during load is held off so a snapshot is never torn
  assign hdr_go    = hdr_valid && (state_ff != lsc_pkg::LSC_ST_LOAD);
  assign hdr_req   = hdr_go && (hdr_id == `LSC_REQ_ID);
  assign hdr_sts   = hdr_go && (state_ff == lsc_pkg::LSC_ST_ARMED) && resp_en_ff
                     && (hdr_id == `LSC_STS_RSP_ID);
  assign hdr_col   = hdr_go && (state_ff == lsc_pkg::LSC_ST_ARMED) && resp_en_ff
                     && (hdr_id == `LSC_COL_RSP_ID);
  assign rsp_go    = hdr_sts || hdr_col;
  assign rx_take   = (state_ff == lsc_pkg::LSC_ST_REQ) && rx_valid && !hdr_valid;
  assign rx_end    = rx_take && (idx_ff == `LSC_REQ_CKS_IDX);
  assign rx_ok     = (rx_byte == rx_chk);
  assign req_match = req_pfx_ok_ff && req_fill_ok_ff
                     && (req_addr_ff == node_addr_ff);
  assign last_idx  = is_col_ff ? `LSC_COL_LAST_IDX : `LSC_STS_LAST_IDX;
  assign load_last = (state_ff == lsc_pkg::LSC_ST_LOAD) && (idx_ff == last_idx);
  assign tx_take   = (state_ff == lsc_pkg::LSC_ST_SEND) && tx_ready && !hdr_valid;
  assign tx_done   = tx_take && tx_last_ff;

  // --------------------------------------------------------------------------
  // status byte and colour payload
  // --------------------------------------------------------------------------
  assign lin_error   = (|lin_err_vec) || cks_err_ff;
  assign status_byte = {diag.thermal_shutdown_flag, diag.thermal_warning_flag, uv_ff,
                        diag.retry_active, led_err, lin_error};
  assign addr_byte   = {`LSC_ADDR_PFX, node_addr_ff};
  assign col_pay[0]  = addr_byte;
  assign col_pay[7]  = {col_snap_ff.fade_on, col_snap_ff.fade_slope, col_snap_ff.fade_time};

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_chan
      assign led_err[g] = |diag.led_channel_error_code[g];
      assign col_pay[1 + 2*g] = col_snap_ff.ch[g].value[7:0];
      assign col_pay[2 + 2*g] = {(g == 2) ? col_snap_ff.intensity : `LSC_UPPER_ONES,
                                 col_snap_ff.ch[g].overflow,
                                 col_snap_ff.ch[g].value[10:8]};
    end
  endgenerate

  assign data_byte = is_col_ff ? col_pay[idx_ff[2:0]]
                   : ((idx_ff == 4'h0) ? addr_byte : sts_snap_ff);
  assign wr_byte   = load_last ? tx_chk : data_byte;

  // --------------------------------------------------------------------------
  // checksums and response buffer
  // --------------------------------------------------------------------------
  lsc_cksum u_rx_cks (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clr     (hdr_req),
    .add     (rx_take && (idx_ff < `LSC_REQ_CKS_IDX)),
    .data    (rx_byte),
    .chk     (rx_chk)
  );

  lsc_cksum u_tx_cks (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clr     (rsp_go),
    .add     ((state_ff == lsc_pkg::LSC_ST_LOAD) && !load_last),
    .data    (data_byte),
    .chk     (tx_chk)
  );

  lsc_resp_mem #(
    .WIDTH (8),
    .DEPTH (16)
  ) u_mem (
    .aclk    (aclk),
    .aresetn (aresetn),
    .wr_en   (state_ff == lsc_pkg::LSC_ST_LOAD),
    .wr_addr (idx_ff),
    .wr_data (wr_byte),
    .rd_addr (idx_ff),
    .rd_data (tx_byte)
  );

  assign tx_valid = (state_ff == lsc_pkg::LSC_ST_SEND);
  assign tx_last  = tx_last_ff;

  // --------------------------------------------------------------------------
  // sequencer
  // --------------------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_idx   = idx_ff;
    if (hdr_go) begin
      nxt_idx   = 4'h0;
      nxt_state = hdr_req ? lsc_pkg::LSC_ST_REQ
                : (rsp_go ? lsc_pkg::LSC_ST_LOAD : lsc_pkg::LSC_ST_IDLE);
    end else begin
      case (state_ff)
        lsc_pkg::LSC_ST_REQ: begin
          if (rx_take) begin
            nxt_idx = idx_ff + 4'h1;
          end
          if (rx_end) begin
            nxt_state = (rx_ok && req_match) ? lsc_pkg::LSC_ST_ARMED
                                             : lsc_pkg::LSC_ST_IDLE;
          end
        end
        lsc_pkg::LSC_ST_LOAD: begin
          nxt_idx = load_last ? 4'h0 : idx_ff + 4'h1;
          if (load_last) begin
            nxt_state = lsc_pkg::LSC_ST_FETCH;
          end
        end
        lsc_pkg::LSC_ST_FETCH: begin
          nxt_state = lsc_pkg::LSC_ST_SEND;
        end
        lsc_pkg::LSC_ST_SEND: begin
          if (tx_take) begin
            nxt_idx   = idx_ff + 4'h1;
            nxt_state = tx_last_ff ? lsc_pkg::LSC_ST_IDLE : lsc_pkg::LSC_ST_FETCH;
          end
        end
        default: begin
          nxt_state = state_ff;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff   <= lsc_pkg::LSC_ST_IDLE;
      idx_ff     <= 4'h0;
      tx_last_ff <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      idx_ff     <= nxt_idx;
      tx_last_ff <= (state_ff == lsc_pkg::LSC_ST_FETCH) ? (idx_ff == last_idx) : tx_last_ff;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req_addr_ff    <= 6'h00;
      req_pfx_ok_ff  <= 1'b0;
      req_fill_ok_ff <= 1'b0;
    end else if (rx_take && (idx_ff == 4'h0)) begin
      req_addr_ff   <= rx_byte[5:0];
      req_pfx_ok_ff <= (rx_byte[7:6] == `LSC_ADDR_PFX);
    end else if (rx_take && (idx_ff == 4'h1)) begin
      req_fill_ok_ff <= (rx_byte == `LSC_FILL_BYTE);
    end
  end

  // serving a response only copies flags; only full_status_clear drops them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      uv_ff       <= 1'b0;
      cks_err_ff  <= 1'b0;
      sts_snap_ff <= 8'h00;
      col_snap_ff <= '0;
      is_col_ff   <= 1'b0;
    end else begin
      uv_ff      <= vbb_uv_event || (uv_ff && !full_status_clear);
      cks_err_ff <= (rx_end && !rx_ok) || (cks_err_ff && !full_status_clear);
      if (rsp_go) begin
        sts_snap_ff <= status_byte;
        col_snap_ff <= color;
        is_col_ff   <= hdr_col;
      end
    end
  end

  // --------------------------------------------------------------------------
  // axi4-lite registers
  // --------------------------------------------------------------------------
  logic        wr_go, rd_go, wr_hit, rd_hit, rd_evt;
  logic [3:0]  evt_set;
  logic [31:0] rd_word;

  assign wr_go   = awvalid && wvalid && !bvalid_ff;
  assign rd_go   = arvalid && !rvalid_ff;
  assign awready = wr_go;
  assign wready  = wr_go;
  assign arready = rd_go;
  assign wr_hit  = (awaddr == `LSC_OFS_CTRL) || (awaddr == `LSC_OFS_MASK)
                   || (awaddr == `LSC_OFS_EVT) || (awaddr == `LSC_OFS_SNAP);
  assign rd_hit  = (araddr == `LSC_OFS_CTRL) || (araddr == `LSC_OFS_MASK)
                   || (araddr == `LSC_OFS_EVT) || (araddr == `LSC_OFS_SNAP);
  assign rd_evt  = rd_go && (araddr == `LSC_OFS_EVT);
  assign rd_word = (araddr == `LSC_OFS_CTRL) ? {23'h0, resp_en_ff, 2'h0, node_addr_ff}
                 : (araddr == `LSC_OFS_EVT)  ? {28'h0, evt_ff}
                 : (araddr == `LSC_OFS_MASK) ? {28'h0, mask_ff}
                 : (araddr == `LSC_OFS_SNAP) ? {23'h0, (state_ff == lsc_pkg::LSC_ST_ARMED),
                                                status_byte}
                 : 32'h0000_0000;

  assign evt_set[`LSC_EVT_STS] = tx_done && !is_col_ff;
  assign evt_set[`LSC_EVT_COL] = tx_done && is_col_ff;
  assign evt_set[`LSC_EVT_CKS] = rx_end && !rx_ok;
  assign evt_set[`LSC_EVT_ADR] = rx_end && rx_ok && !req_match;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      node_addr_ff <= `LSC_NODE_ADDR_RST;
      resp_en_ff   <= `LSC_RESP_EN_RST;
      mask_ff      <= `LSC_MASK_RST;
    end else if (wr_go && (awaddr == `LSC_OFS_CTRL)) begin
      node_addr_ff <= wstrb[0] ? wdata[5:0] : node_addr_ff;
      resp_en_ff   <= wstrb[1] ? wdata[`LSC_CTRL_EN_BIT] : resp_en_ff;
    end else if (wr_go && (awaddr == `LSC_OFS_MASK) && wstrb[0]) begin
      mask_ff <= wdata[3:0];
    end
  end

  // a set in the cycle of the clearing read survives
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evt_ff <= 4'h0;
      irq_ff <= 1'b0;
    end else begin
      evt_ff <= evt_set | (evt_ff & ~{4{rd_evt}});
      irq_ff <= |(evt_ff & mask_ff);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= `LSC_RESP_OKAY;
      rvalid_ff <= 1'b0;
      rresp_ff  <= `LSC_RESP_OKAY;
      rdata_ff  <= 32'h0000_0000;
    end else begin
      if (wr_go) begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= wr_hit ? `LSC_RESP_OKAY : `LSC_RESP_SLVERR;
      end else if (bready) begin
        bvalid_ff <= 1'b0;
      end
      if (rd_go) begin
        rvalid_ff <= 1'b1;
        rresp_ff  <= rd_hit ? `LSC_RESP_OKAY : `LSC_RESP_SLVERR;
        rdata_ff  <= rd_word;
      end else if (rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  assign bvalid = bvalid_ff;
  assign bresp  = bresp_ff;
  assign rvalid = rvalid_ff;
  assign rresp  = rresp_ff;
  assign rdata  = rdata_ff;
  assign irq    = irq_ff;

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_col_go;
    hdr_col;
  endsequence
  sequence s_sts_go;
    hdr_sts;
  endsequence

  property p_uv_hold;
    $fell(uv_ff) |-> $past(full_status_clear);
  endproperty
  a_uv_hold: assert property (p_uv_hold) else $error("uv flag dropped without clear");

  property p_uv_set;
    vbb_uv_event |=> uv_ff ##1 (uv_ff || $past(full_status_clear));
  endproperty
  a_uv_set: assert property (p_uv_set) else $error("uv flag not latched");

  property p_sts_tsd;
    s_sts_go |=> sts_snap_ff[7] == $past(diag.thermal_shutdown_flag);
  endproperty
  a_sts_tsd: assert property (p_sts_tsd) else $error("thermal shutdown bit wrong");

  property p_sts_lin;
    s_sts_go ##0 (|lin_err_vec) |=> sts_snap_ff[0];
  endproperty
  a_sts_lin: assert property (p_sts_lin) else $error("lin error bit missing");

  property p_sts_led;
    s_sts_go |=> sts_snap_ff[3] == $past(|diag.led_channel_error_code[2]);
  endproperty
  a_sts_led: assert property (p_sts_led) else $error("led3 error bit wrong");

  property p_sts_retry;
    s_sts_go |=> sts_snap_ff[4] == $past(diag.retry_active);
  endproperty
  a_sts_retry: assert property (p_sts_retry) else $error("retry bit wrong");

  property p_col_len;
    s_col_go |=> (state_ff == lsc_pkg::LSC_ST_LOAD)[*8] ##1 load_last ##1
                 (state_ff == lsc_pkg::LSC_ST_FETCH);
  endproperty
  a_col_len: assert property (p_col_len) else $error("colour frame length wrong");

  property p_col_low;
    s_col_go |-> ##2 wr_byte == $past(color.ch[0].value[7:0], 2);
  endproperty
  a_col_low: assert property (p_col_low) else $error("channel 1 low byte wrong");

  property p_col_up1;
    s_col_go |-> ##3 wr_byte == {`LSC_UPPER_ONES, $past(color.ch[0].overflow, 3),
                                 $past(color.ch[0].value[10:8], 3)};
  endproperty
  a_col_up1: assert property (p_col_up1) else $error("channel 1 upper byte wrong");

  property p_col_up3;
    s_col_go |-> ##7 wr_byte[7:3] == {$past(color.intensity, 7), $past(color.ch[2].overflow, 7)};
  endproperty
  a_col_up3: assert property (p_col_up3) else $error("channel 3 upper byte wrong");

  property p_rx_bad_cks;
    rx_end && !rx_ok |=> evt_ff[`LSC_EVT_CKS] && (state_ff == lsc_pkg::LSC_ST_IDLE);
  endproperty
  a_rx_bad_cks: assert property (p_rx_bad_cks) else $error("bad checksum accepted");

  property p_addr_miss;
    rx_end && (req_addr_ff != node_addr_ff) |=> state_ff != lsc_pkg::LSC_ST_ARMED;
  endproperty
  a_addr_miss: assert property (p_addr_miss) else $error("foreign address armed");
endmodule

// ==== src/lsc_consts.svh ====
/*
  Constants of the LIN status and modulation readback block: frame identifiers,
  frame layout, register offsets, field positions and reset values.
  Assumes inclusion by bare name from every file that needs them.
*/
`ifndef LSC_CONSTS_SVH
`define LSC_CONSTS_SVH

// ----------------------------------------------------------------------------
// frame identifiers and layout
// ----------------------------------------------------------------------------
`define LSC_REQ_ID         8'h20
`define LSC_STS_RSP_ID     8'h11
`define LSC_COL_RSP_ID     8'h92
`define LSC_FILL_BYTE      8'hFF
`define LSC_ADDR_PFX       2'h3
`define LSC_REQ_CKS_IDX    4'h2
`define LSC_STS_LAST_IDX   4'h2
`define LSC_COL_LAST_IDX   4'h8
`define LSC_UPPER_ONES     4'hF

// ----------------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------------
`define LSC_OFS_CTRL       4'h0
`define LSC_OFS_EVT        4'h4
`define LSC_OFS_MASK       4'h8
`define LSC_OFS_SNAP       4'hC
`define LSC_CTRL_EN_BIT    8
`define LSC_SNAP_ARM_BIT   8
`define LSC_EVT_STS        0
`define LSC_EVT_COL        1
`define LSC_EVT_CKS        2
`define LSC_EVT_ADR        3
`define LSC_NODE_ADDR_RST  6'h00
`define LSC_RESP_EN_RST    1'h1
`define LSC_MASK_RST       4'h0
`define LSC_RESP_OKAY      2'h0
`define LSC_RESP_SLVERR    2'h2

`endif

// ==== src/lsc_pkg.sv ====
/*
  Types of the LIN status and modulation readback block.
  Assumes nothing of its surroundings.
*/
package lsc_pkg;

  typedef enum logic [2:0] {
    LSC_ST_IDLE,
    LSC_ST_REQ,
    LSC_ST_ARMED,
    LSC_ST_LOAD,
    LSC_ST_FETCH,
    LSC_ST_SEND
  } lsc_state_t;

  typedef struct packed {
    logic        overflow;
    logic [10:0] value;
  } lsc_mod_t;

  typedef struct packed {
    lsc_mod_t [2:0] ch;
    logic [3:0]     intensity;
    logic           fade_on;
    logic           fade_slope;
    logic [5:0]     fade_time;
  } lsc_color_t;

  typedef struct packed {
    logic           thermal_shutdown_flag;
    logic           thermal_warning_flag;
    logic           retry_active;
    logic [2:0][2:0] led_channel_error_code;
  } lsc_diag_t;

endpackage

// ==== src/lsc_cksum.sv ====
/*
  Classic LIN checksum accumulator: eight-bit sum with end-around carry.
  Assumes the caller clears it before the first byte of a frame.
*/
`timescale 1ns/1ps
module lsc_cksum (
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // byte stream
  input  wire logic       clr,
  input  wire logic       add,
  input  wire logic [7:0] data,
  // result
  output logic      [7:0] chk
);
  logic [7:0] sum_ff;
  logic [7:0] base;
  logic [8:0] raw;
  logic [7:0] folded;
  logic [7:0] nxt_sum;

  assign base    = clr ? 8'h00 : sum_ff;
  assign raw     = {1'b0, base} + {1'b0, data};
  assign folded  = raw[7:0] + {7'h00, raw[8]};
  assign nxt_sum = add ? folded : base;
  assign chk     = ~sum_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sum_ff <= 8'h00;
    end else begin
      sum_ff <= nxt_sum;
    end
  end
endmodule

// ==== src/lsc_resp_mem.sv ====
/*
  Small response buffer: one write port, one read port with registered data.
  Assumes one clock; read data follows the address by one edge.
*/
`timescale 1ns/1ps
module lsc_resp_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int AW    = $clog2(DEPTH)
) (
  // clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // write port
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  // read port
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge aclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule

// ==== dv/lsc_lin_master.sv ====
/*
  LIN master node model: sends request frames and headers, collects response bytes.
  Assumes its tasks are called from one bench process.
*/
`timescale 1ns/1ps
`include "lsc_consts.svh"
module lsc_lin_master (
  // clock
  input  wire logic       aclk,
  // headers and request bytes
  output logic            hdr_valid,
  output logic      [7:0] hdr_id,
  output logic            rx_valid,
  output logic      [7:0] rx_byte,
  // response bytes
  input  wire logic       tx_valid,
  output logic            tx_ready,
  input  wire logic [7:0] tx_byte,
  input  wire logic       tx_last
);
  logic [7:0] rsp[$];
  logic [7:0] acc = 8'h00;
  logic       slow = 1'b0;
  logic       cks_ok = 1'b0;
  initial begin
    {hdr_valid, hdr_id, rx_valid, rx_byte, tx_ready} = '0;
  end
  function automatic logic [7:0] eac(input logic [7:0] s, input logic [7:0] b);
    logic [8:0] t;
    t = {1'b0, s} + {1'b0, b};
    return t[7:0] + {7'h00, t[8]};
  endfunction
  // released lines show the inverse so a stale value is never taken
  task automatic put(input logic [7:0] b);
    @(posedge aclk);
    rx_valid <= 1'b1;
    rx_byte  <= b;
    @(posedge aclk);
    rx_valid <= 1'b0;
    rx_byte  <= ~b;
  endtask
  task automatic hdr(input logic [7:0] id);
    @(posedge aclk);
    hdr_valid <= 1'b1;
    hdr_id    <= id;
    @(posedge aclk);
    hdr_valid <= 1'b0;
    hdr_id    <= ~id;
  endtask
  task automatic request(input logic [7:0] a, input logic bad);
    hdr(`LSC_REQ_ID);
    put(a);
    put(`LSC_FILL_BYTE);
    put(~eac(a, `LSC_FILL_BYTE) ^ {7'h00, bad});
  endtask
  task automatic clear();
    rsp.delete();
    acc = 8'h00;
    cks_ok = 1'b0;
  endtask
  // stalls every other cycle when slow, like a busy frame engine
  always @(posedge aclk) begin
    tx_ready <= slow ? ~tx_ready : 1'b1;
    if (tx_valid && tx_ready) begin
      rsp.push_back(tx_byte);
      if (tx_last) begin
        cks_ok <= (tx_byte === ~acc);
        acc    <= 8'h00;
      end else begin
        acc <= eac(acc, tx_byte);
      end
    end
  end
endmodule

// ==== dv/tb_lsc_readback.sv ====
/*
  Self-checking bench of the readback block: AXI4-Lite master tasks and LIN master model.
  Assumes the design's hand-over timing and register map.
*/
`timescale 1ns/1ps
`include "lsc_consts.svh"
module tb_lsc_readback;
  logic                aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic                arvalid = 0, rready = 0, vbb_uv_event = 0, full_status_clear = 0;
  logic [3:0]          awaddr = 0, araddr = 0, wstrb = 0, lin_err_vec = 0;
  logic [31:0]         wdata = 0, rdata, seed = 32'hC510, d;
  logic [1:0]          bresp, rresp, r;
  logic                awready, wready, bvalid, arready, rvalid, irq, uv_exp = 0, loc_err = 0;
  logic                hdr_valid, rx_valid, tx_valid, tx_ready, tx_last;
  logic [7:0]          hdr_id, rx_byte, tx_byte;
  logic [5:0]          node;
  logic [63:0]         c;
  lsc_pkg::lsc_diag_t  diag = '0;
  lsc_pkg::lsc_color_t color = '0;
  int                  n_mismatch = 0, n_checks = 0, cyc = 0;
  always #50 aclk = ~aclk;
  lsc_readback #(.LIN_ERR_W(4)) dut_u (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .hdr_valid, .hdr_id, .rx_valid, .rx_byte, .tx_valid, .tx_ready,
    .tx_byte, .tx_last, .diag, .lin_err_vec, .vbb_uv_event, .full_status_clear, .color, .irq);
  lsc_lin_master mst_u (.aclk, .hdr_valid, .hdr_id, .rx_valid, .rx_byte, .tx_valid,
    .tx_ready, .tx_byte, .tx_last);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (exp !== got) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge aclk);
    {awaddr, wdata, wstrb} <= {a, v, 4'hF};
    {awvalid, wvalid, bready} <= 3'b111;
    do @(negedge aclk); while (!awready);
    @(posedge aclk);
    {awvalid, wvalid} <= 2'b00;
    do @(negedge aclk); while (!bvalid);
    @(posedge aclk);
    chk("bresp", `LSC_RESP_OKAY, bresp);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    do @(negedge aclk); while (!arready);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (!rvalid);
    @(posedge aclk);
    {d, r} = {rdata, rresp};
    rready <= 1'b0;
  endtask
  function automatic logic [7:0] sts_exp();
    return {diag.thermal_shutdown_flag, diag.thermal_warning_flag, uv_exp, diag.retry_active,
      diag.led_channel_error_code[2] != 0, diag.led_channel_error_code[1] != 0,
      diag.led_channel_error_code[0] != 0, (|lin_err_vec) | loc_err};
  endfunction
  function automatic logic [63:0] col_exp();
    return {2'b11, node, color.ch[0].value[7:0], 4'hF, color.ch[0].overflow,
      color.ch[0].value[10:8], color.ch[1].value[7:0], 4'hF, color.ch[1].overflow,
      color.ch[1].value[10:8], color.ch[2].value[7:0], color.intensity, color.ch[2].overflow,
      color.ch[2].value[10:8], color.fade_on, color.fade_slope, color.fade_time};
  endfunction
  // n data bytes expected in the low bytes of e, first byte highest
  task automatic query(input logic [7:0] a, input logic [7:0] id, input int n,
                       input logic [63:0] e);
    mst_u.clear();
    mst_u.request(a, 1'b0);
    mst_u.hdr(id);
    repeat (300) if (mst_u.rsp.size() < n + 1) @(posedge aclk);
    repeat (2) @(negedge aclk);
    chk("rsp_len", (a[5:0] == node) ? n + 1 : 0, mst_u.rsp.size());
    for (int i = 0; i < n && i < mst_u.rsp.size(); i++) chk("rsp", e[8*(n-1-i) +: 8], mst_u.rsp[i]);
    if (a[5:0] == node) chk("rsp_cks", 1, mst_u.cks_ok);
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      final_report();
    end
  end
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`LSC_OFS_CTRL);
    chk("ctrl_rst", 32'h100, d);
    rd(`LSC_OFS_MASK);
    chk("mask_rst", 0, d);
    rd(4'h2);
    chk("unmapped", `LSC_RESP_SLVERR, r);
    node = 6'(rnd());
    wr(`LSC_OFS_CTRL, {23'h0, 1'b1, 2'h0, node});
    for (int i = 0; i < 6; i++) begin
      mst_u.slow = i[0];
      d = rnd();
      c = {rnd(), rnd()};
      @(posedge aclk);
      {diag, lin_err_vec, color} <= {d[11:0], (i > 2) ? d[15:12] : 4'h0, c[47:0]};
      {vbb_uv_event, full_status_clear} <= {i == 2, i == 4};
      @(posedge aclk);
      {vbb_uv_event, full_status_clear} <= 2'b00;
      if (i == 2) uv_exp = 1'b1;
      if (i == 4) {uv_exp, loc_err} = 2'b00;
      wr(`LSC_OFS_MASK, i[1] ? 32'hF : 32'h0);
      if (i == 0) begin
        mst_u.request({2'b11, node}, 1'b0);
        rd(`LSC_OFS_SNAP);
        chk("snap", {23'h0, 1'b1, sts_exp()}, d);
        wr(`LSC_OFS_CTRL, {26'h0, node});
        mst_u.clear();
        mst_u.hdr(`LSC_STS_RSP_ID);
        repeat (20) @(posedge aclk);
        chk("rsp_off", 0, mst_u.rsp.size());
        wr(`LSC_OFS_CTRL, {23'h0, 1'b1, 2'h0, node});
      end
      if (i == 3) begin
        mst_u.request({2'b11, node}, 1'b1);
        rd(`LSC_OFS_EVT);
        chk("evt_cks", 32'h4, d);
        loc_err = 1'b1;
      end
      if (i == 5) begin
        query({2'b11, ~node}, `LSC_STS_RSP_ID, 2, 0);
        rd(`LSC_OFS_EVT);
        chk("evt_adr", 32'h8, d);
      end
      query({2'b11, node}, `LSC_STS_RSP_ID, 2, {2'b11, node, sts_exp()});
      chk("irq_sts", i[1], irq);
      rd(`LSC_OFS_EVT);
      chk("evt_sts", 32'h1, d);
      query({2'b11, node}, `LSC_COL_RSP_ID, 8, col_exp());
      chk("irq_col", i[1], irq);
      rd(`LSC_OFS_EVT);
      chk("evt_col", 32'h2, d);
    end
    final_report();
  end
endmodule
